/* File: mr_cfg_pkg.sv */
// Purpose: Shared constants for the mode register link between controller and memory device
// Assumes: One clock, clk_sys, on both ends
// Notes:   Register values are 8 bits wide

package mr_cfg_pkg;

   // ****************************************
   // Mode register addresses
   // ****************************************
   localparam logic [7:0] BURST_AND_RECOVERY_CONFIG_ADDR   = 8'h01;
   localparam logic [7:0] LATENCY_AND_LEVELING_CONFIG_ADDR = 8'h02;
   localparam logic [7:0] OUTPUT_DRIVE_CONFIG_ADDR         = 8'h03;

   // ****************************************
   // Values after reset
   // ****************************************
   localparam logic [7:0] BURST_AND_RECOVERY_RESET   = 8'h03;
   localparam logic [7:0] LATENCY_AND_LEVELING_RESET = 8'h18;
   localparam logic [7:0] OUTPUT_DRIVE_RESET         = 8'h02;

   // ****************************************
   // Masks of defined bits; others are reserved
   // ****************************************
   localparam logic [7:0] BURST_AND_RECOVERY_MASK   = 8'hE7;
   localparam logic [7:0] LATENCY_AND_LEVELING_MASK = 8'hDF;
   localparam logic [7:0] OUTPUT_DRIVE_MASK         = 8'h0F;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int BURST_LENGTH_LSB     = 0;
   localparam int WRITE_RECOVERY_LSB   = 5;
   localparam int LATENCY_LSB          = 0;
   localparam int RANGE_EXT_BIT        = 4;
   localparam int SET_SELECT_BIT       = 6;
   localparam int LEVELING_BIT         = 7;
   localparam int DRIVE_LSB            = 0;
   localparam logic [2:0] BURST_LENGTH_EIGHT = 3'h3;

   // ****************************************
   // Burst and read answer
   // ****************************************
   localparam logic [3:0] BURST_BEATS      = 4'h8;
   localparam logic [7:0] WRITE_ONLY_RDATA = 8'h00;

   // ****************************************
   // Controller's own registers
   // ****************************************
   localparam logic [7:0] CTRL_STATUS_ADDR  = 8'hF0;
   localparam logic [7:0] CTRL_MRR_ADDR     = 8'hF1;
   localparam logic [7:0] CTRL_MRR_DATA     = 8'hF2;
   localparam logic [7:0] CTRL_WR_AUTO_ADDR = 8'hF3;

   // ****************************************
   // Write recovery timing of the memory link
   // ****************************************
   localparam int WRITE_RECOVERY_TIME_PS = 15000;
   localparam int LINK_CLK_PERIOD_PS     = 1250;
   localparam int WRITE_RECOVERY_CYCLES_MIN =
      (WRITE_RECOVERY_TIME_PS + LINK_CLK_PERIOD_PS - 1) / LINK_CLK_PERIOD_PS;

endpackage : mr_cfg_pkg

/* File: mr_link_if.sv */
// Purpose: Link between memory controller and device mode register logic
// Assumes: Single clock domain
// Notes:   One-cycle command pulses

`timescale 1ns/100ps
`default_nettype none

interface mr_link_if;
   logic       mrw_valid;
   logic       mrr_valid;
   logic [7:0] mode_reg_addr;
   logic [7:0] mode_reg_operand;
   logic       burst_start;
   logic [1:0] burst_col_hi;
   logic       auto_precharge_done;
   logic       rd_valid;
   logic [7:0] rd_data;
   logic       dqs_toggle;

   modport device (
      input  mrw_valid, mrr_valid, mode_reg_addr, mode_reg_operand,
      input  burst_start, burst_col_hi, auto_precharge_done,
      output rd_valid, rd_data, dqs_toggle
   );
   modport controller (
      output mrw_valid, mrr_valid, mode_reg_addr, mode_reg_operand,
      output burst_start, burst_col_hi, auto_precharge_done,
      input  rd_valid, rd_data, dqs_toggle
   );
endinterface : mr_link_if

`default_nettype wire

/* File: mr_device.sv */
// Purpose: Device end: write-only mode registers, field decode, burst order, precharge timing
// Assumes: Controller keeps reserved codes, except recovery codes, and reserved bits out of its writes
// Notes:   Decoded reserved codes show as zero and carry no meaning
//
// Contract
// - Address 01 holds burst length, recovery cycles
// - Burst length code only 011, eight beats
// - Range ext 0: recovery 3,6,8,9 cycles
// - Range ext 1: recovery 10,11,12,14,16 cycles
// - Auto precharge starts after recovery cycles
// - Controller rounds recovery time up to cycles
// - Eight-beat burst wraps sequentially from start column
// - Lowest column bit taken as zero
// - Address 02 holds latency, range, set, leveling
// - Set A latency code decode to pairs
// - Bit 4 selects recovery range
// - Set select bit kept at zero
// - Bit 7 enables write leveling
// - Address 03 symmetric drive strength decode
// - Asymmetric drive strength codes also accepted
// - Controller writes zero to reserved bits
// - Read of write-only returns undefined, strobes toggle

`timescale 1ns/100ps
`default_nettype none

module mr_device (
   input  wire logic     clk_sys,
   input  wire logic     rst,
   mr_link_if.device     link,
   output logic [4:0]    write_recovery_cycles,
   output logic          write_recovery_range_ext,
   output logic [4:0]    read_latency,
   output logic [3:0]    write_latency,
   output logic          write_latency_set_select,
   output logic          write_leveling_en,
   output logic [3:0]    drive_strength_code,
   output logic [9:0]    pull_down_ohm_x10,
   output logic [9:0]    pull_up_ohm_x10,
   output logic          burst_eight,
   output logic          burst_active,
   output logic [2:0]    burst_col,
   output logic          precharge_start
);

   // ****************************************
   // Mode registers
   // ****************************************
   logic [7:0] burst_and_recovery_config_r;
   logic [7:0] burst_and_recovery_config_nxt;
   logic [7:0] latency_and_leveling_config_r;
   logic [7:0] latency_and_leveling_config_nxt;
   logic [7:0] output_drive_config_r;
   logic [7:0] output_drive_config_nxt;
   logic       rd_valid_r;
   logic       rd_valid_nxt;
   logic [7:0] rd_data_r;

   always_comb begin
      burst_and_recovery_config_nxt   = burst_and_recovery_config_r;
      latency_and_leveling_config_nxt = latency_and_leveling_config_r;
      output_drive_config_nxt         = output_drive_config_r;
      if (link.mrw_valid) begin
         case (link.mode_reg_addr)
            mr_cfg_pkg::BURST_AND_RECOVERY_CONFIG_ADDR: begin
               burst_and_recovery_config_nxt = link.mode_reg_operand;
            end
            mr_cfg_pkg::LATENCY_AND_LEVELING_CONFIG_ADDR: begin
               latency_and_leveling_config_nxt = link.mode_reg_operand;
            end
            mr_cfg_pkg::OUTPUT_DRIVE_CONFIG_ADDR: begin
               output_drive_config_nxt = link.mode_reg_operand;
            end
            default: begin
            end
         endcase
      end
      // Every read is answered; these registers hold nothing readable
      rd_valid_nxt = link.mrr_valid;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         burst_and_recovery_config_r   <= mr_cfg_pkg::BURST_AND_RECOVERY_RESET;
         latency_and_leveling_config_r <= mr_cfg_pkg::LATENCY_AND_LEVELING_RESET;
         output_drive_config_r         <= mr_cfg_pkg::OUTPUT_DRIVE_RESET;
         rd_valid_r                    <= 1'b0;
         rd_data_r                     <= mr_cfg_pkg::WRITE_ONLY_RDATA;
      end else begin
         burst_and_recovery_config_r   <= burst_and_recovery_config_nxt;
         latency_and_leveling_config_r <= latency_and_leveling_config_nxt;
         output_drive_config_r         <= output_drive_config_nxt;
         rd_valid_r                    <= rd_valid_nxt;
         rd_data_r                     <= mr_cfg_pkg::WRITE_ONLY_RDATA;
      end
   end

   assign link.rd_valid   = rd_valid_r;
   assign link.rd_data    = rd_data_r;
   assign link.dqs_toggle = rd_valid_r;

   // ****************************************
   // Field decode
   // ****************************************
   logic [2:0] burst_code;
   logic [2:0] recovery_code;
   logic [3:0] latency_code;

   assign burst_code    = burst_and_recovery_config_r[mr_cfg_pkg::BURST_LENGTH_LSB +: 3];
   assign recovery_code = burst_and_recovery_config_r[mr_cfg_pkg::WRITE_RECOVERY_LSB +: 3];
   assign latency_code  = latency_and_leveling_config_r[mr_cfg_pkg::LATENCY_LSB +: 4];
   assign write_recovery_range_ext =
      latency_and_leveling_config_r[mr_cfg_pkg::RANGE_EXT_BIT];
   assign write_latency_set_select =
      latency_and_leveling_config_r[mr_cfg_pkg::SET_SELECT_BIT];
   assign write_leveling_en =
      latency_and_leveling_config_r[mr_cfg_pkg::LEVELING_BIT];
   assign drive_strength_code = output_drive_config_r[mr_cfg_pkg::DRIVE_LSB +: 4];
   assign burst_eight = (burst_code == mr_cfg_pkg::BURST_LENGTH_EIGHT);

   always_comb begin
      write_recovery_cycles = 5'h00;
      if (!write_recovery_range_ext) begin
         case (recovery_code)
            3'h1:    write_recovery_cycles = 5'h03;
            3'h4:    write_recovery_cycles = 5'h06;
            3'h6:    write_recovery_cycles = 5'h08;
            3'h7:    write_recovery_cycles = 5'h09;
            default: write_recovery_cycles = 5'h00;
         endcase
      end else begin
         case (recovery_code)
            3'h0:    write_recovery_cycles = 5'h0A;
            3'h1:    write_recovery_cycles = 5'h0B;
            3'h2:    write_recovery_cycles = 5'h0C;
            3'h4:    write_recovery_cycles = 5'h0E;
            3'h6:    write_recovery_cycles = 5'h10;
            default: write_recovery_cycles = 5'h00;
         endcase
      end
   end

   always_comb begin
      read_latency  = 5'h00;
      write_latency = 4'h0;
      if (!write_latency_set_select) begin
         case (latency_code)
            4'h4: begin read_latency = 5'h06; write_latency = 4'h3; end
            4'h6: begin read_latency = 5'h08; write_latency = 4'h4; end
            4'h7: begin read_latency = 5'h09; write_latency = 4'h5; end
            4'h8: begin read_latency = 5'h0A; write_latency = 4'h6; end
            4'h9: begin read_latency = 5'h0B; write_latency = 4'h6; end
            4'hA: begin read_latency = 5'h0C; write_latency = 4'h6; end
            4'hC: begin read_latency = 5'h0E; write_latency = 4'h8; end
            4'hE: begin read_latency = 5'h10; write_latency = 4'h8; end
            default: begin read_latency = 5'h00; write_latency = 4'h0; end
         endcase
      end
   end

   always_comb begin
      case (drive_strength_code)
         4'h1: begin pull_down_ohm_x10 = 10'h157; pull_up_ohm_x10 = 10'h157; end
         4'h2: begin pull_down_ohm_x10 = 10'h190; pull_up_ohm_x10 = 10'h190; end
         4'h3: begin pull_down_ohm_x10 = 10'h1E0; pull_up_ohm_x10 = 10'h1E0; end
         4'h4: begin pull_down_ohm_x10 = 10'h258; pull_up_ohm_x10 = 10'h258; end
         4'h6: begin pull_down_ohm_x10 = 10'h320; pull_up_ohm_x10 = 10'h320; end
         4'h9: begin pull_down_ohm_x10 = 10'h157; pull_up_ohm_x10 = 10'h190; end
         4'hA: begin pull_down_ohm_x10 = 10'h190; pull_up_ohm_x10 = 10'h1E0; end
         4'hB: begin pull_down_ohm_x10 = 10'h157; pull_up_ohm_x10 = 10'h1E0; end
         default: begin pull_down_ohm_x10 = 10'h000; pull_up_ohm_x10 = 10'h000; end
      endcase
   end

   // ****************************************
   // Burst address sequence
   // ****************************************
   logic [2:0] burst_col_r;
   logic [2:0] burst_col_nxt;
   logic [3:0] beats_left_r;
   logic [3:0] beats_left_nxt;

   always_comb begin
      burst_col_nxt  = burst_col_r;
      beats_left_nxt = beats_left_r;
      if (link.burst_start) begin
         burst_col_nxt  = {link.burst_col_hi, 1'b0};
         beats_left_nxt = mr_cfg_pkg::BURST_BEATS;
      end else if (beats_left_r != 4'h0) begin
         // Three-bit wrap gives modulo-8 order for free
         burst_col_nxt  = burst_col_r + 3'h1;
         beats_left_nxt = beats_left_r - 4'h1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         burst_col_r  <= 3'h0;
         beats_left_r <= 4'h0;
      end else begin
         burst_col_r  <= burst_col_nxt;
         beats_left_r <= beats_left_nxt;
      end
   end

   assign burst_active = (beats_left_r != 4'h0);
   assign burst_col    = burst_col_r;

   // ****************************************
   // Write recovery before internal precharge
   // ****************************************
   logic [4:0] wr_cnt_r;
   logic [4:0] wr_cnt_nxt;
   logic       precharge_r;
   logic       precharge_nxt;

   always_comb begin
      wr_cnt_nxt    = wr_cnt_r;
      precharge_nxt = 1'b0;
      if (link.auto_precharge_done) begin
         wr_cnt_nxt = write_recovery_cycles;
      end else if (wr_cnt_r != 5'h00) begin
         wr_cnt_nxt    = wr_cnt_r - 5'h01;
         precharge_nxt = (wr_cnt_r == 5'h01);
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_cnt_r    <= 5'h00;
         precharge_r <= 1'b0;
      end else begin
         wr_cnt_r    <= wr_cnt_nxt;
         precharge_r <= precharge_nxt;
      end
   end

   assign precharge_start = precharge_r;

endmodule : mr_device

`default_nettype wire

/* File: mr_controller.sv */
// Purpose: Controller end: turns software writes into clean mode register writes
// Assumes: Software uses the plain register port, one strobe per cycle
// Notes:   Writes with reserved burst length, latency or drive codes, or set B, are refused and flagged; recovery codes are not checked

`timescale 1ns/100ps
`default_nettype none

module mr_controller (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   mr_link_if.controller    link,
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   output logic [7:0]       rdata,
   input  wire logic        burst_req,
   input  wire logic [1:0]  burst_col_hi,
   input  wire logic        auto_precharge_done
);

   // ****************************************
   // Code legality
   // ****************************************
   logic [7:0] mr_addr;
   logic [7:0] mr_op;
   logic       legal;
   logic       is_mr;
   logic [2:0] wr_code;

   // Smallest extended-range recovery code not below the rounded-up cycle count, else the 16-cycle code
   always_comb begin
      if (mr_cfg_pkg::WRITE_RECOVERY_CYCLES_MIN <= 10)      wr_code = 3'h0;
      else if (mr_cfg_pkg::WRITE_RECOVERY_CYCLES_MIN <= 11) wr_code = 3'h1;
      else if (mr_cfg_pkg::WRITE_RECOVERY_CYCLES_MIN <= 12) wr_code = 3'h2;
      else if (mr_cfg_pkg::WRITE_RECOVERY_CYCLES_MIN <= 14) wr_code = 3'h4;
      else                                                   wr_code = 3'h6;
   end

   always_comb begin
      mr_addr = addr;
      mr_op   = wdata;
      if (addr == mr_cfg_pkg::CTRL_WR_AUTO_ADDR) begin
         mr_addr = mr_cfg_pkg::BURST_AND_RECOVERY_CONFIG_ADDR;
         mr_op   = {wr_code, 2'b00, mr_cfg_pkg::BURST_LENGTH_EIGHT};
      end
      is_mr = 1'b1;
      legal = 1'b1;
      case (mr_addr)
         mr_cfg_pkg::BURST_AND_RECOVERY_CONFIG_ADDR: begin
            mr_op = mr_op & mr_cfg_pkg::BURST_AND_RECOVERY_MASK;
            legal = (mr_op[2:0] == mr_cfg_pkg::BURST_LENGTH_EIGHT);
         end
         mr_cfg_pkg::LATENCY_AND_LEVELING_CONFIG_ADDR: begin
            mr_op = mr_op & mr_cfg_pkg::LATENCY_AND_LEVELING_MASK;
            legal = !mr_op[mr_cfg_pkg::SET_SELECT_BIT] &&
                    (mr_op[3:0] inside {4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC, 4'hE});
         end
         mr_cfg_pkg::OUTPUT_DRIVE_CONFIG_ADDR: begin
            mr_op = mr_op & mr_cfg_pkg::OUTPUT_DRIVE_MASK;
            legal = (mr_op[3:0] inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h9, 4'hA, 4'hB});
         end
         default: begin
            is_mr = 1'b0;
            legal = 1'b0;
         end
      endcase
   end

   // ****************************************
   // Link drive and own registers
   // ****************************************
   logic       mrw_r;
   logic       mrw_nxt;
   logic       mrr_r;
   logic       mrr_nxt;
   logic [7:0] cmd_addr_r;
   logic [7:0] cmd_addr_nxt;
   logic [7:0] cmd_data_r;
   logic [7:0] cmd_data_nxt;
   logic       reject_r;
   logic       reject_nxt;
   logic [7:0] mrr_data_r;
   logic [7:0] mrr_data_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   always_comb begin
      mrw_nxt      = 1'b0;
      mrr_nxt      = 1'b0;
      cmd_addr_nxt = cmd_addr_r;
      cmd_data_nxt = cmd_data_r;
      reject_nxt   = reject_r;
      mrr_data_nxt = mrr_data_r;
      rdata_nxt    = 8'h00;
      if (wr_stb && addr == mr_cfg_pkg::CTRL_STATUS_ADDR && wdata[0]) begin
         reject_nxt = 1'b0;
      end
      if (wr_stb && addr == mr_cfg_pkg::CTRL_MRR_ADDR) begin
         mrr_nxt = 1'b1;
         cmd_addr_nxt = wdata;
      end else if (wr_stb && is_mr) begin
         if (legal) begin
            mrw_nxt = 1'b1;
            cmd_addr_nxt = mr_addr;
            cmd_data_nxt = mr_op;
         end else begin
            // Set wins over a clear in the same write
            reject_nxt = 1'b1;
         end
      end
      if (link.rd_valid) begin
         mrr_data_nxt = link.rd_data;
      end
      if (rd_stb) begin
         case (addr)
            mr_cfg_pkg::CTRL_STATUS_ADDR: rdata_nxt = {7'h00, reject_r};
            mr_cfg_pkg::CTRL_MRR_DATA:    rdata_nxt = mrr_data_r;
            default:                      rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mrw_r      <= 1'b0;
         mrr_r      <= 1'b0;
         cmd_addr_r <= 8'h00;
         cmd_data_r <= 8'h00;
         reject_r   <= 1'b0;
         mrr_data_r <= 8'h00;
         rdata_r    <= 8'h00;
      end else begin
         mrw_r      <= mrw_nxt;
         mrr_r      <= mrr_nxt;
         cmd_addr_r <= cmd_addr_nxt;
         cmd_data_r <= cmd_data_nxt;
         reject_r   <= reject_nxt;
         mrr_data_r <= mrr_data_nxt;
         rdata_r    <= rdata_nxt;
      end
   end

   assign link.mrw_valid        = mrw_r;
   assign link.mrr_valid        = mrr_r;
   assign link.mode_reg_addr    = cmd_addr_r;
   assign link.mode_reg_operand = cmd_data_r;
   assign link.burst_start      = burst_req;
   assign link.burst_col_hi     = burst_col_hi;
   assign link.auto_precharge_done = auto_precharge_done;
   assign rdata                 = rdata_r;

endmodule : mr_controller

`default_nettype wire

/* File: mr_link_monitor.sv */
// Purpose: Protocol checks on the mode register link between both ends
// Assumes: One clock, rst active high and asynchronous
// Notes:   Sees the link signals only; decoded outputs are judged by the bench

`timescale 1ns/100ps
`default_nettype none

module mr_link_monitor (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       mrw_valid,
   input  wire logic       mrr_valid,
   input  wire logic [7:0] mode_reg_addr,
   input  wire logic [7:0] mode_reg_operand,
   input  wire logic       rd_valid,
   input  wire logic       dqs_toggle
);
   // ****************************************
   // Link checks
   // ****************************************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence cfg1_wr; mrw_valid && mode_reg_addr == 8'h01; endsequence
   sequence cfg2_wr; mrw_valid && mode_reg_addr == 8'h02; endsequence
   sequence cfg3_wr; mrw_valid && mode_reg_addr == 8'h03; endsequence
   // A read answer is a single beat, so the strobe must drop again
   sequence rd_pulse; rd_valid ##1 !rd_valid; endsequence

   burst_eight_a: assert property (cfg1_wr |-> mode_reg_operand[2:0] == 3'h3)
      else $error("burst length code not eight");
   rec_code_a: assert property (cfg1_wr |-> mode_reg_operand[7:5] != 3'h3
      && mode_reg_operand[7:5] != 3'h5) else $error("recovery code reserved");
   rsv_bits_a: assert property (mrw_valid |-> !(mode_reg_addr == 8'h01
      && |mode_reg_operand[4:3]) && !(mode_reg_addr == 8'h02 && mode_reg_operand[5])
      && !(mode_reg_addr == 8'h03 && |mode_reg_operand[7:4]))
      else $error("reserved bit written high");
   lat_code_a: assert property (cfg2_wr |-> mode_reg_operand[3:0] inside
      {4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC, 4'hE}) else $error("latency code reserved");
   set_a_only_a: assert property (cfg2_wr |-> !mode_reg_operand[6])
      else $error("latency set B selected");
   drive_code_a: assert property (cfg3_wr |-> mode_reg_operand[3:0] inside
      {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h9, 4'hA, 4'hB}) else $error("drive code reserved");
   mrr_answer_a: assert property (mrr_valid |=> rd_pulse)
      else $error("read answer missing");
   rd_cause_a: assert property (rd_valid |-> $past(mrr_valid))
      else $error("read answer without request");
   strobe_pair_a: assert property (rd_valid || dqs_toggle |-> rd_valid && dqs_toggle)
      else $error("strobe not toggled with answer");
endmodule // mr_link_monitor

`default_nettype wire

/* File: dram_feature_mode_regs_tb.sv */
// Purpose: Self-checking bench, controller and device joined over the link
// Assumes: Expected values come from the legal code tables below
// Notes:   Results are compared in order by one watcher process

`timescale 1ns/100ps
`default_nettype none

`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
   $display("wrong value t=%0t compare mismatch", $time); end end

module dram_feature_mode_regs_tb;
   logic        clk_sys, rst, wr_stb, rd_stb, burst_req, auto_precharge_done, rd_seen, snap_r;
   logic        write_recovery_range_ext, write_latency_set_select, write_leveling_en;
   logic        burst_eight, burst_active, precharge_start, lev, ext;
   logic [7:0]  addr, wdata, rdata;
   logic [1:0]  burst_col_hi;
   logic [2:0]  burst_col;
   logic [4:0]  write_recovery_cycles, read_latency, pre_cnt;
   logic [3:0]  write_latency, drive_strength_code;
   logic [9:0]  pull_down_ohm_x10, pull_up_ohm_x10;
   logic [41:0] e;
   logic [41:0] dec_now;
   logic [41:0] exp_q[$];
   int          err_total = 0, samples_checked = 0, cyc = 0;
   // Legal codes and their decoded values, index matched
   logic [3:0]  lat_c[8] = '{4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC, 4'hE};
   logic [4:0]  rdlat_v[8] = '{5'h06, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h10};
   logic [3:0]  wrlat_v[8] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h6, 4'h6, 4'h8, 4'h8};
   logic [3:0]  drv_c[8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h9, 4'hA, 4'hB};
   logic [9:0]  pd_v[8] = '{10'h157, 10'h190, 10'h1E0, 10'h258, 10'h320, 10'h157, 10'h190,
                            10'h157};
   logic [9:0]  pu_v[8] = '{10'h157, 10'h190, 10'h1E0, 10'h258, 10'h320, 10'h190, 10'h1E0,
                            10'h1E0};
   logic [2:0]  wr_c[9] = '{3'h1, 3'h4, 3'h6, 3'h7, 3'h0, 3'h1, 3'h2, 3'h4, 3'h6};
   logic [4:0]  wr_v[9] = '{5'h03, 5'h06, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h10};

   mr_link_if mr_link_if_i ();
   mr_device mr_device_i (.clk_sys(clk_sys), .rst(rst), .link(mr_link_if_i.device),
      .write_recovery_cycles(write_recovery_cycles),
      .write_recovery_range_ext(write_recovery_range_ext),
      .read_latency(read_latency), .write_latency(write_latency),
      .write_latency_set_select(write_latency_set_select), .write_leveling_en(write_leveling_en),
      .drive_strength_code(drive_strength_code), .pull_down_ohm_x10(pull_down_ohm_x10),
      .pull_up_ohm_x10(pull_up_ohm_x10), .burst_eight(burst_eight), .burst_active(burst_active),
      .burst_col(burst_col), .precharge_start(precharge_start));
   mr_controller mr_controller_i (.clk_sys(clk_sys), .rst(rst), .link(mr_link_if_i.controller),
      .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .burst_req(burst_req), .burst_col_hi(burst_col_hi),
      .auto_precharge_done(auto_precharge_done));
   mr_link_monitor mr_link_monitor_i (.clk_sys(clk_sys), .rst(rst),
      .mrw_valid(mr_link_if_i.mrw_valid), .mrr_valid(mr_link_if_i.mrr_valid),
      .mode_reg_addr(mr_link_if_i.mode_reg_addr), .mode_reg_operand(mr_link_if_i.mode_reg_operand),
      .rd_valid(mr_link_if_i.rd_valid), .dqs_toggle(mr_link_if_i.dqs_toggle));
   assign dec_now = {write_recovery_cycles, write_recovery_range_ext, read_latency,
      write_latency, write_latency_set_select, write_leveling_en, drive_strength_code,
      pull_down_ohm_x10, pull_up_ohm_x10, burst_eight};

   // ****************************************
   // Clock, tasks and result watcher
   // ****************************************
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   function automatic logic [41:0] mk(input logic [4:0] n, input logic x, input logic [4:0] rl,
      input logic [3:0] wl, input logic lv, input logic [3:0] d, input logic [9:0] pd,
      input logic [9:0] pu);
      return {n, x, rl, wl, 1'b0, lv, d, pd, pu, 1'b1};
   endfunction

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      exp_q.push_back({34'h0, x});
      @(posedge clk_sys);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      @(posedge clk_sys);
   endtask

   // Decoded outputs are levels, so they are sampled on request
   task automatic snap(input logic [41:0] x);
      exp_q.push_back(x);
      repeat (2) @(posedge clk_sys);
      snap_r <= 1'b1;
      @(posedge clk_sys);
      snap_r <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic pre(input logic [4:0] n);
      exp_q.push_back({37'h0, n});
      @(posedge clk_sys);
      auto_precharge_done <= 1'b1;
      @(posedge clk_sys);
      auto_precharge_done <= 1'b0;
      repeat (20) @(posedge clk_sys);
   endtask

   task automatic burst(input logic [1:0] b);
      for (int k = 0; k < 8; k++) exp_q.push_back({39'h0, 3'({b, 1'b0} + k)});
      @(posedge clk_sys);
      burst_req <= 1'b1;
      burst_col_hi <= b;
      @(posedge clk_sys);
      burst_req <= 1'b0;
      repeat (10) @(posedge clk_sys);
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   always @(posedge clk_sys) begin
      rd_seen <= rd_stb;
      // Count starts at the edge that takes the done pulse
      pre_cnt <= auto_precharge_done ? 5'h00 : pre_cnt + 5'h01;
      cyc <= cyc + 1;
      if (rd_seen) `CHK(rdata, exp_q.pop_front())
      if (snap_r) `CHK(dec_now, exp_q.pop_front())
      if (precharge_start) `CHK(pre_cnt, exp_q.pop_front())
      if (burst_active) `CHK(burst_col, exp_q.pop_front())
      if (cyc == 5000) begin
         err_total++;
         print_verdict();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {addr, wdata, wr_stb, rd_stb, burst_req, burst_col_hi, auto_precharge_done, snap_r} = '0;
      rst = 1'b1;
      void'($urandom(73));
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      e = mk(5'h0A, 1'b1, 5'h0A, 4'h6, 1'b0, 4'h2, 10'h190, 10'h190);
      snap(e);
      rd(8'hF0, 8'h00);
      rd(8'h40, 8'h00);
      $display("test reset done");
      wr(8'hF3, 8'h5A);
      e = mk(5'h0C, 1'b1, 5'h0A, 4'h6, 1'b0, 4'h2, 10'h190, 10'h190);
      snap(e);
      pre(5'h0C);
      $display("test rounded recovery done");
      for (int i = 0; i < 9; i++) begin
         lev = 1'($urandom);
         ext = (i >= 4);
         wr(8'h02, {lev, 1'b0, 1'($urandom), ext, lat_c[i % 8]});
         wr(8'h01, {wr_c[i], 2'($urandom), 3'h3});
         wr(8'h03, {4'($urandom), drv_c[i % 8]});
         e = mk(wr_v[i], ext, rdlat_v[i % 8], wrlat_v[i % 8], lev, drv_c[i % 8], pd_v[i % 8],
            pu_v[i % 8]);
         snap(e);
         pre(wr_v[i]);
         burst(2'($urandom));
      end
      $display("test code tables done");
      wr(8'h01, 8'h02);
      wr(8'h02, 8'h48);
      wr(8'h02, 8'h11);
      wr(8'h03, 8'h05);
      snap(e);
      rd(8'hF0, 8'h01);
      wr(8'hF0, 8'h01);
      rd(8'hF0, 8'h00);
      wr(8'hF1, 8'h01);
      repeat (3) @(posedge clk_sys);
      rd(8'hF2, mr_cfg_pkg::WRITE_ONLY_RDATA);
      repeat (4) @(posedge clk_sys);
      $display("test refusals done");
      print_verdict();
   end
endmodule // dram_feature_mode_regs_tb

`default_nettype wire
